//--- hw/fpr_defs.vh
// Shared constants for the flash power and reset mode controller.
`ifndef FPR_DEFS_VH
`define FPR_DEFS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FPR_CLK_PERIOD_PS 8000
`define FPR_RESET_PULSE_MIN_EMB_US 25
`define FPR_RESET_PULSE_MIN_READ_US 5
`define FPR_RESET_HIGH_TO_READ_NS 200
`define FPR_RESET_PULSE_MIN_EMB_CYC ((`FPR_RESET_PULSE_MIN_EMB_US * 1000000 + `FPR_CLK_PERIOD_PS - 1) / `FPR_CLK_PERIOD_PS)
`define FPR_RESET_PULSE_MIN_READ_CYC ((`FPR_RESET_PULSE_MIN_READ_US * 1000000 + `FPR_CLK_PERIOD_PS - 1) / `FPR_CLK_PERIOD_PS)
`define FPR_RESET_HIGH_TO_READ_CYC ((`FPR_RESET_HIGH_TO_READ_NS * 1000 + `FPR_CLK_PERIOD_PS - 1) / `FPR_CLK_PERIOD_PS)
`define FPR_SLEEP_IDLE_CYC 64

// ----------------------------------------------------------------------------
// Power states
// ----------------------------------------------------------------------------
`define FPR_ST_RESET 3'h0
`define FPR_ST_RECOVER 3'h1
`define FPR_ST_ACTIVE 3'h2
`define FPR_ST_STANDBY 3'h3
`define FPR_ST_SLEEP 3'h4

// ----------------------------------------------------------------------------
// Read regions
// ----------------------------------------------------------------------------
`define FPR_RG_ARRAY 3'h0
`define FPR_RG_SEC_LOCK 3'h1
`define FPR_RG_SECURED 3'h2
`define FPR_RG_CONFIG 3'h3
`define FPR_RG_IDENT 3'h4

`endif

//--- hw/fpr_sync.v
// Two-flop synchroniser bank for pins from outside the clock domain.
`timescale 1ns/10ps
module fpr_sync #(
   parameter WIDTH = 1
) (
   input wire clock_in,              // System clock.
   input wire srst_in,               // Synchronous reset, active high.
   input wire [WIDTH-1:0] async_in,  // Asynchronous pin levels.
   output wire [WIDTH-1:0] sync_out  // Synchronised levels.
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock_in) begin
            if (srst_in) begin
               meta_r[i] <= 1'b1;
               sync_r[i] <= 1'b1;
            end else begin
               meta_r[i] <= async_in[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate
   assign sync_out = sync_r;
endmodule // fpr_sync

//--- hw/fpr_ctrl.v
// Power state, output enable and reset sequencing for a multiplexed-bus flash.
//
// Contract
// - Standby when reset pin and chip enable are high, unless embedded operation runs.
// - In standby, ignore write and output enable; float all data pins.
// - Enter automatic sleep by itself when address and clock stay stable.
// - Automatic sleep ignores chip enable, write enable and output enable; here chip enable high leaves sleep for standby.
// - During sleep, keep last output data latched and driven.
// - After sleep, new address gets data in normal access time, no wake delay.
// - Never enter automatic sleep while in burst read mode.
// - Output enable high floats the multiplexed address/data pins.
// - Output enable has no effect on the ready output.
// - Reset low at least 25 us during embedded operation, 5 us in reads.
// - After reset release, ready for reads; host waits 200 ns.
// - Software reset command leaves special regions and returns to array read.
`timescale 1ns/10ps
`include "fpr_defs.vh"
module fpr_ctrl #(
   parameter AW = 16,
   parameter DW = 16,
   parameter PULSE_EMB_CYC = `FPR_RESET_PULSE_MIN_EMB_CYC,
   parameter PULSE_READ_CYC = `FPR_RESET_PULSE_MIN_READ_CYC,
   parameter SLEEP_CYC = `FPR_SLEEP_IDLE_CYC
) (
   input wire clock_in,                 // Internal clock.
   input wire srst_in,                  // Synchronous reset, active high.
   input wire reset_n_in,               // Reset pin, active low.
   input wire ce_n_in,                  // Chip enable pin, active low.
   input wire we_n_in,                  // Write enable pin, active low.
   input wire oe_n_in,                  // Output enable pin, active low.
   input wire burst_clk_in,             // Burst clock pin.
   input wire [AW-1:0] addr_in,         // Latched address from bus front end.
   input wire [DW-1:0] array_data_in,   // Data from the array for addr_in.
   input wire embedded_busy_in,         // Program or erase in progress.
   input wire sync_mode_in,             // Burst read mode selected.
   input wire region_enter_in,          // Pulse: command enters a region.
   input wire [2:0] region_sel_in,      // Region being entered.
   input wire soft_reset_in,            // Pulse: software reset command decoded.
   output reg [DW-1:0] dq_out_out,      // Data driven on the bus.
   output reg dq_oe_out,                // Bus output enable, high drives.
   output reg rdy_out,                  // Ready indication.
   output reg [2:0] state_out,          // Power state.
   output reg [2:0] region_out,         // Current read region.
   output reg read_ok_out,              // Device accepts reads.
   output reg reset_abort_out,          // Pulse: embedded operation aborted.
   output reg we_gate_out               // Write strobe passed to command logic.
);

   // -------------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------------
   wire [4:0] pins_s;
   fpr_sync #(
      .WIDTH(5)
   ) u_sync (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .async_in({reset_n_in, ce_n_in, we_n_in, oe_n_in, burst_clk_in}),
      .sync_out(pins_s)
   );
   wire rst_n_s = pins_s[4];
   wire ce_n_s = pins_s[3];
   wire we_n_s = pins_s[2];
   wire oe_n_s = pins_s[1];
   wire bclk_s = pins_s[0];

   // -------------------------------------------------------------------------
   // Activity detection
   // -------------------------------------------------------------------------
   // The clock pin is only sampled, so activity is any observed level change.
   reg bclk_d_r;
   reg [AW-1:0] addr_d_r;
   reg [15:0] idle_cnt_r;
   reg [15:0] idle_cnt_nxt;
   wire activity = (bclk_s != bclk_d_r) || (addr_in != addr_d_r);

   // -------------------------------------------------------------------------
   // Reset pulse measurement
   // -------------------------------------------------------------------------
   reg [31:0] low_cnt_r;
   reg emb_at_low_r;
   reg [7:0] rec_cnt_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   wire pulse_ok = emb_at_low_r ? (low_cnt_r >= PULSE_EMB_CYC) : (low_cnt_r >= PULSE_READ_CYC);

   always @(posedge clock_in) begin
      if (srst_in) begin
         bclk_d_r <= 1'b0;
         addr_d_r <= {AW{1'b0}};
         idle_cnt_r <= 16'h0000;
         low_cnt_r <= 32'h0000_0000;
         emb_at_low_r <= 1'b0;
         rec_cnt_r <= 8'h00;
      end else begin
         bclk_d_r <= bclk_s;
         addr_d_r <= addr_in;
         idle_cnt_r <= idle_cnt_nxt;
         if (!rst_n_s) begin
            if (low_cnt_r != 32'hFFFF_FFFF)
               low_cnt_r <= low_cnt_r + 32'h0000_0001;
            if (embedded_busy_in)
               emb_at_low_r <= 1'b1;
         end else begin
            // Cleared on every high cycle so that short pulses never add up to a valid one.
            // The state machine still sees the old count on the first high cycle.
            low_cnt_r <= 32'h0000_0000;
            emb_at_low_r <= 1'b0;
         end
         if (state_r == `FPR_ST_RECOVER)
            rec_cnt_r <= rec_cnt_r + 8'h01;
         else
            rec_cnt_r <= 8'h00;
      end
   end

   always @* begin
      idle_cnt_nxt = idle_cnt_r;
      if (activity || sync_mode_in || state_r != `FPR_ST_ACTIVE && state_r != `FPR_ST_SLEEP)
         idle_cnt_nxt = 16'h0000;
      else if (idle_cnt_r < SLEEP_CYC[15:0])
         idle_cnt_nxt = idle_cnt_r + 16'h0001;
   end

   // -------------------------------------------------------------------------
   // Power state machine
   // -------------------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `FPR_ST_RESET: begin
            // A pulse shorter than the minimum is not honoured; the device stays held.
            if (rst_n_s && pulse_ok)
               state_nxt = `FPR_ST_RECOVER;
         end
         `FPR_ST_RECOVER: begin
            if (!rst_n_s)
               state_nxt = `FPR_ST_RESET;
            else if (rec_cnt_r >= `FPR_RESET_HIGH_TO_READ_CYC - 1)
               state_nxt = `FPR_ST_ACTIVE;
         end
         `FPR_ST_ACTIVE, `FPR_ST_STANDBY, `FPR_ST_SLEEP: begin
            if (!rst_n_s)
               state_nxt = `FPR_ST_RESET;
            else if (ce_n_s && !embedded_busy_in)
               state_nxt = `FPR_ST_STANDBY;
            else if (sync_mode_in || activity)
               state_nxt = `FPR_ST_ACTIVE;
            else if (idle_cnt_r >= SLEEP_CYC[15:0])
               state_nxt = `FPR_ST_SLEEP;
            else
               state_nxt = `FPR_ST_ACTIVE;
         end
         default: state_nxt = `FPR_ST_RESET;
      endcase
   end

   // -------------------------------------------------------------------------
   // Outputs and region tracking
   // -------------------------------------------------------------------------
   reg [DW-1:0] held_data_r;
   wire in_standby = (state_nxt == `FPR_ST_STANDBY);
   wire in_reset = (state_nxt == `FPR_ST_RESET) || (state_nxt == `FPR_ST_RECOVER);

   always @(posedge clock_in) begin
      if (srst_in) begin
         state_r <= `FPR_ST_RESET;
         state_out <= `FPR_ST_RESET;
         region_out <= `FPR_RG_ARRAY;
         held_data_r <= {DW{1'b0}};
         dq_out_out <= {DW{1'b0}};
         dq_oe_out <= 1'b0;
         rdy_out <= 1'b0;
         read_ok_out <= 1'b0;
         reset_abort_out <= 1'b0;
         we_gate_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         state_out <= state_nxt;
         reset_abort_out <= (state_r != `FPR_ST_RESET) && (state_nxt == `FPR_ST_RESET) && embedded_busy_in;
         if (in_reset || soft_reset_in)
            region_out <= `FPR_RG_ARRAY;
         else if (region_enter_in && !in_standby)
            region_out <= region_sel_in;
         // Sleep freezes the array read so the bus keeps the last word.
         if (state_nxt == `FPR_ST_ACTIVE)
            held_data_r <= array_data_in;
         if (state_nxt == `FPR_ST_ACTIVE)
            dq_out_out <= array_data_in;
         else
            dq_out_out <= held_data_r;
         dq_oe_out <= !in_standby && !in_reset && !oe_n_s;
         we_gate_out <= !in_standby && !in_reset && !we_n_s && !ce_n_s;
         rdy_out <= !in_reset;
         read_ok_out <= !in_reset;
      end
   end

endmodule // fpr_ctrl

//--- verif/fpr_ctrl_properties.sv
// Concurrent checks on the ports of the power and reset controller.
`timescale 1ns/10ps
`include "fpr_defs.vh"
module fpr_ctrl_properties #(
   parameter PULSE_READ_CYC = 8
) (
   input wire clock_in, // Controller clock.
   input wire srst_in, // Synchronous reset, active high.
   input wire reset_n_in, // Reset pin, active low.
   input wire ce_n_in, // Chip enable pin, active low.
   input wire oe_n_in, // Output enable pin, active low.
   input wire embedded_busy_in, // Program or erase in progress.
   input wire sync_mode_in, // Burst read mode selected.
   input wire [15:0] addr_in, // Address from the bus front end.
   input wire soft_reset_in, // Software reset command pulse.
   input wire [15:0] dq_out_out, // Data driven on the bus.
   input wire dq_oe_out, // Bus output enable.
   input wire rdy_out, // Ready indication.
   input wire [2:0] state_out, // Power state.
   input wire [2:0] region_out // Current read region.
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   // Length of the latest low stretch on the reset pin.
   int run_len_r = 0;
   int last_len_r = 0;
   always @(posedge clock_in) begin
      run_len_r <= reset_n_in ? 0 : run_len_r + 1;
      if (reset_n_in && run_len_r != 0) last_len_r <= run_len_r;
   end
   sequence s_rec_start;
      state_out == `FPR_ST_RECOVER && $past(state_out) == `FPR_ST_RESET;
   endsequence
   property p_stby_enter;
      state_out == `FPR_ST_ACTIVE && ce_n_in && $past(ce_n_in) && $past(ce_n_in, 2) && reset_n_in
         && !embedded_busy_in && !sync_mode_in |=> state_out == `FPR_ST_STANDBY;
   endproperty
   a_stby_enter: assert property (p_stby_enter) else $error("standby not entered");
   property p_stby_float;
      state_out == `FPR_ST_STANDBY && $past(state_out) == `FPR_ST_STANDBY |-> !dq_oe_out;
   endproperty
   a_stby_float: assert property (p_stby_float) else $error("bus driven in standby");
   property p_sleep_hold;
      state_out == `FPR_ST_SLEEP && $past(state_out) == `FPR_ST_SLEEP |-> $stable(dq_out_out);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("data lost in sleep");
   property p_wake;
      state_out == `FPR_ST_SLEEP && $changed(addr_in) |=> state_out != `FPR_ST_SLEEP;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on address change");
   property p_no_sleep_burst;
      sync_mode_in && $past(sync_mode_in) |-> state_out != `FPR_ST_SLEEP;
   endproperty
   a_no_sleep_burst: assert property (p_no_sleep_burst) else $error("sleep in burst mode");
   property p_oe_float;
      oe_n_in && $past(oe_n_in) && $past(oe_n_in, 2) && $past(oe_n_in, 3) |-> !dq_oe_out;
   endproperty
   a_oe_float: assert property (p_oe_float) else $error("bus driven with output enable off");
   property p_rdy_oe;
      rdy_out && $changed(oe_n_in) && reset_n_in && $past(reset_n_in) && $past(reset_n_in, 2)
         && $past(reset_n_in, 3) |=> rdy_out;
   endproperty
   a_rdy_oe: assert property (p_rdy_oe) else $error("ready follows output enable");
   property p_pulse;
      s_rec_start |-> last_len_r >= PULSE_READ_CYC;
   endproperty
   a_pulse: assert property (p_pulse) else $error("short reset pulse accepted");
   property p_recover;
      s_rec_start |-> (state_out == `FPR_ST_RECOVER)[*8] ##18 state_out == `FPR_ST_ACTIVE;
   endproperty
   a_recover: assert property (p_recover) else $error("recovery time wrong");
   property p_soft;
      soft_reset_in |=> region_out == `FPR_RG_ARRAY;
   endproperty
   a_soft: assert property (p_soft) else $error("software reset kept region");
   c_sleep: cover property (state_out == `FPR_ST_SLEEP);
   c_stby: cover property (state_out == `FPR_ST_STANDBY);
   c_rec: cover property (s_rec_start);
endmodule // fpr_ctrl_properties
bind fpr_ctrl fpr_ctrl_properties #(.PULSE_READ_CYC(PULSE_READ_CYC)) u_props (.clock_in, .srst_in, .reset_n_in,
   .ce_n_in, .oe_n_in, .embedded_busy_in, .sync_mode_in, .addr_in, .soft_reset_in, .dq_out_out, .dq_oe_out,
   .rdy_out, .state_out, .region_out);

//--- verif/fpr_host.sv
// Host side model: burst clock at the link rate and the array contents.
`timescale 1ns/10ps
module fpr_host (
   input wire run_in, // Burst clock runs while high.
   input wire [15:0] addr_in, // Address being read.
   output logic burst_clk_out, // Burst clock pin.
   output wire [15:0] array_data_out // Array word for addr_in.
);
   // The clock stands low between bursts, so a quiet bus really looks quiet.
   initial begin
      burst_clk_out = 1'b0;
      #3;
      forever begin
         #80;
         burst_clk_out = run_in ? ~burst_clk_out : 1'b0;
      end
   end
   assign array_data_out = {addr_in[7:0], ~addr_in[15:8]};
endmodule // fpr_host

//--- verif/flash_power_reset_modes_bench.sv
// Self-checking bench for the flash power and reset controller.
`timescale 1ns/10ps
`include "fpr_defs.vh"
module flash_power_reset_modes_bench;
   logic clock_in = 0, srst_in = 1, reset_n_in = 1, ce_n_in = 0, we_n_in = 1, oe_n_in = 0, embedded_busy_in = 0;
   logic sync_mode_in = 0, run = 0, region_enter_in = 0, soft_reset_in = 0;
   logic [2:0] region_sel_in = 0;
   logic [15:0] addr_in = 16'h0000;
   logic [15:0] next_addr = 16'h0000;
   // Reference model: addresses presented so far, newest last.
   logic [15:0] addr_q[$] = '{16'h0000};
   int abort_seen = 0;
   wire burst_clk_in, dq_oe_out, rdy_out, read_ok_out, reset_abort_out, we_gate_out;
   wire [15:0] array_data_in, dq_out_out;
   wire [2:0] state_out, region_out;
   int err_count = 0;
   int comparisons = 0;
   int tab [4][3] = '{'{0, 8, 1}, '{0, 3, 0}, '{1, 12, 0}, '{1, 20, 1}};
   initial forever #4 clock_in = ~clock_in;
   fpr_host host (.run_in(run), .addr_in(addr_in), .burst_clk_out(burst_clk_in), .array_data_out(array_data_in));
   fpr_ctrl #(.PULSE_EMB_CYC(20), .PULSE_READ_CYC(8), .SLEEP_CYC(4)) DUT (.clock_in, .srst_in, .reset_n_in,
      .ce_n_in, .we_n_in, .oe_n_in, .burst_clk_in, .addr_in, .array_data_in, .embedded_busy_in, .sync_mode_in,
      .region_enter_in, .region_sel_in, .soft_reset_in, .dq_out_out, .dq_oe_out, .rdy_out, .state_out,
      .region_out, .read_ok_out, .reset_abort_out, .we_gate_out);
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Array word that the host side returns for an address.
   function automatic logic [15:0] model_word(logic [15:0] a);
      return {a[7:0], ~a[15:8]};
   endfunction
   task automatic cyc(int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic finish_test;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      finish_test;
   end
   initial begin
      void'($urandom(32'ha6c4dd30));
      cyc(3);
      srst_in <= 0;
      sync_mode_in <= 1;
      for (int i = 0; i < 4; i++) begin
         embedded_busy_in <= tab[i][0];
         reset_n_in <= 0;
         cyc(tab[i][1]);
         reset_n_in <= 1;
         embedded_busy_in <= 0;
         cyc(40);
         chk("state", tab[i][2] ? `FPR_ST_ACTIVE : `FPR_ST_RESET, state_out);
         chk("ready", tab[i][2], rdy_out);
         chk("read_ok", tab[i][2], read_ok_out);
      end
      $display("Test reset pulses done");
      sync_mode_in <= 0;
      repeat (3) begin
         cyc(20);
         chk("sleep", `FPR_ST_SLEEP, state_out);
         we_n_in <= 0;
         cyc(6);
         we_n_in <= 1;
         chk("sleep_we", `FPR_ST_SLEEP, state_out);
         chk("sleep_we_gate", 1, we_gate_out);
         chk("sleep_data", model_word(addr_q[$]), dq_out_out);
         chk("sleep_drive", 1, dq_oe_out);
         // An odd mask guarantees that the address really changes.
         next_addr = addr_in ^ (16'($urandom) | 16'h0001);
         addr_q.push_back(next_addr);
         addr_in <= next_addr;
         cyc(2);
         chk("wake", `FPR_ST_ACTIVE, state_out);
         chk("wake_data", model_word(addr_q[$]), dq_out_out);
      end
      $display("Test sleep done");
      sync_mode_in <= 1;
      run <= 1;
      cyc(30);
      chk("burst", `FPR_ST_ACTIVE, state_out);
      oe_n_in <= 1;
      cyc(5);
      chk("oe_float", 0, dq_oe_out);
      chk("oe_ready", 1, rdy_out);
      oe_n_in <= 0;
      cyc(5);
      chk("oe_drive", 1, dq_oe_out);
      $display("Test burst and output enable done");
      sync_mode_in <= 0;
      run <= 0;
      ce_n_in <= 1;
      cyc(5);
      chk("standby", `FPR_ST_STANDBY, state_out);
      chk("stby_float", 0, dq_oe_out);
      embedded_busy_in <= 1;
      cyc(5);
      chk("busy_no_stby", 1, state_out != `FPR_ST_STANDBY);
      embedded_busy_in <= 0;
      ce_n_in <= 0;
      // Chip enable needs two sync stages and one edge before standby is left.
      cyc(4);
      $display("Test standby done");
      for (int r = 1; r < 5; r++) begin
         region_sel_in <= r;
         region_enter_in <= 1;
         cyc(1);
         region_enter_in <= 0;
         cyc(2);
         chk("region", r, region_out);
         soft_reset_in <= 1;
         cyc(1);
         soft_reset_in <= 0;
         cyc(2);
         chk("array", `FPR_RG_ARRAY, region_out);
      end
      $display("Test software reset done");
      embedded_busy_in <= 1;
      reset_n_in <= 0;
      repeat (20) begin
         cyc(1);
         abort_seen += reset_abort_out;
      end
      reset_n_in <= 1;
      embedded_busy_in <= 0;
      chk("abort", 1, abort_seen);
      cyc(40);
      chk("abort_ready", 1, rdy_out);
      chk("abort_read_ok", 1, read_ok_out);
      $display("Test reset abort done");
      finish_test;
   end
endmodule // flash_power_reset_modes_bench
